// File: hdl/idp_axil.sv
// module: axi4-lite slave front end that turns bus transfers into register strobes
module idp_axil
  import idp_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write channels
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // axi4-lite read channels
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // register side
  output logic wr_en,
  output logic [ADDR_W-1:0] wr_addr,
  output logic [31:0] wr_data,
  output logic [3:0] wr_strb,
  output logic [ADDR_W-1:0] rd_addr,
  input wire logic [31:0] rd_data
);

  typedef struct packed {
    logic awready;
    logic wready;
    logic have_aw;
    logic have_w;
    logic [ADDR_W-1:0] waddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic wr_en;
    logic arready;
    logic rpend;
    logic [ADDR_W-1:0] raddr;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } idp_axil_s;

  idp_axil_s st_reg;
  idp_axil_s st_next;

  // ******************************************************
  // next state
  // ******************************************************
  // address and data may come in either order; the response waits for both
  always_comb begin
    st_next = st_reg;
    st_next.wr_en = 1'b0;
    if (awvalid && st_reg.awready) begin
      st_next.have_aw = 1'b1;
      st_next.waddr = awaddr;
    end
    if (wvalid && st_reg.wready) begin
      st_next.have_w = 1'b1;
      st_next.wdata = wdata;
      st_next.wstrb = wstrb;
    end
    // both halves held: one register strobe for a mapped address, with the response in the same cycle
    if (st_reg.have_aw && st_reg.have_w && !st_reg.bvalid) begin
      st_next.wr_en = idp_mapped(st_reg.waddr);
      st_next.bresp = idp_mapped(st_reg.waddr) ? RESP_OKAY : RESP_SLVERR;
      st_next.bvalid = 1'b1;
      st_next.have_aw = 1'b0;
      st_next.have_w = 1'b0;
    end
    if (st_reg.bvalid && bready) begin
      st_next.bvalid = 1'b0;
    end
    // read: address one cycle, mux settles, data the next
    if (arvalid && st_reg.arready) begin
      st_next.rpend = 1'b1;
      st_next.raddr = araddr;
    end
    if (st_reg.rpend) begin
      st_next.rpend = 1'b0;
      st_next.rvalid = 1'b1;
      st_next.rdata = idp_mapped(st_reg.raddr) ? rd_data : 32'h0000_0000;
      st_next.rresp = idp_mapped(st_reg.raddr) ? RESP_OKAY : RESP_SLVERR;
    end
    if (st_reg.rvalid && rready) begin
      st_next.rvalid = 1'b0;
    end
    // one transfer of each kind at a time
    st_next.awready = !st_next.have_aw && !st_next.bvalid;
    st_next.wready = !st_next.have_w && !st_next.bvalid;
    st_next.arready = !st_next.rpend && !st_next.rvalid;
  end

  // ******************************************************
  // state register
  // ******************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign awready = st_reg.awready;
  assign wready = st_reg.wready;
  assign bresp = st_reg.bresp;
  assign bvalid = st_reg.bvalid;
  assign arready = st_reg.arready;
  assign rdata = st_reg.rdata;
  assign rresp = st_reg.rresp;
  assign rvalid = st_reg.rvalid;
  assign wr_en = st_reg.wr_en;
  assign wr_addr = st_reg.waddr;
  assign wr_data = st_reg.wdata;
  assign wr_strb = st_reg.wstrb;
  assign rd_addr = st_reg.raddr;

endmodule

// File: hdl/idp_check.sv
// module: combinational verdict of one descriptor against the entry fields
module idp_check
  import idp_pkg::*;
(
  // entry fields
  input wire logic usable,
  input wire logic lock,
  input wire logic [1:0] etype,
  input wire logic [ID_W-1:0] sub_id,
  input wire logic wen,
  input wire logic ren,
  // descriptor
  input wire logic [ID_W-1:0] pasid,
  input wire logic is_rd,
  input wire logic is_wr,
  input wire logic is_upd,
  // verdict
  output logic [3:0] err,
  output logic need_bitmap
);

  // ******************************************************
  // checks in priority order
  // ******************************************************
  // the first failing check names the error; no access is made on any error
  always_comb begin
    err = ERR_NONE;
    need_bitmap = 1'b0;
    if (!usable) begin
      err = ERR_UNUSABLE;
    end else if (etype != TYPE_SINGLE && etype != TYPE_MULTI) begin
      err = ERR_TYPE;
    end else if (is_upd && !lock) begin
      err = ERR_UPDATE;
    end else if (is_wr && !wen) begin
      err = ERR_WRITE;
    end else if (is_rd && !ren) begin
      err = ERR_READ;
    end else if (etype == TYPE_SINGLE && pasid != sub_id) begin
      err = ERR_SUBMIT;
    end else if (etype == TYPE_MULTI) begin
      need_bitmap = 1'b1;
    end
  end

endmodule

// File: hdl/idp_top.sv
// module: permission table entry registers and the descriptor check sequencer
// the check sees the entry fields as they stand before the edge that
// takes the request, so a register write landing in that same cycle
// only affects the following descriptor
// a multi-submitter entry that passes the other checks needs one bitmap lookup, during which the
// request port is closed; every other verdict comes one edge after
// the request is taken
module idp_top
  import idp_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write channels
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // axi4-lite read channels
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // descriptor check request from the engine
  input wire logic req_valid,
  output logic req_ready,
  input wire logic [ID_W-1:0] req_pasid,
  input wire logic req_priv,
  input wire logic req_rd,
  input wire logic req_wr,
  input wire logic req_upd,
  // check answer
  output logic rsp_valid,
  output logic rsp_ok,
  output logic [3:0] rsp_err,
  output logic [ID_W-1:0] rsp_acc_id,
  output logic rsp_priv,
  // submitter bitmap lookup in memory
  output logic bm_req,
  output logic [ID_W-1:0] bm_pasid,
  input wire logic bm_ack,
  input wire logic bm_bit,
  // interrupt
  output logic irq
);

  // ******************************************************
  // state
  // ******************************************************
  // all state sits in one struct: the next-state process fills a copy
  // and the register process copies it back on each edge
  typedef struct packed {
    logic [ID_W-1:0] sub_id;  // submitter identity
    logic [1:0] etype;        // entry type
    logic lock;               // update-lock flag
    logic usable;             // usable flag
    logic [ID_W-1:0] acc_id;  // access identity
    logic priv;               // access privilege control
    logic wen;                // write permission
    logic ren;                // read permission
    logic [EVT_W-1:0] status; // sticky events
    logic [EVT_W-1:0] mask;   // interrupt enables
    logic [3:0] last_err;     // code of the latest verdict
    idp_state_e state;        // sequencer state
    logic ready;              // request port open
    logic rsp_valid;          // one-cycle answer strobe
    logic rsp_ok;
    logic [3:0] rsp_err;
    logic [ID_W-1:0] rsp_acc_id;
    logic rsp_priv;
    logic bm_req;             // bitmap lookup pending
    logic [ID_W-1:0] bm_pasid;
    logic irq;
  } idp_top_s;

  idp_top_s st_reg;
  idp_top_s st_next;

  // register strobes from the bus slave
  logic wr_en;
  logic [ADDR_W-1:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic [ADDR_W-1:0] rd_addr;
  logic [31:0] rd_data;

  // verdict of the checker
  logic [3:0] chk_err;
  logic chk_need_bm;

  // packed views of the two entry words
  logic [31:0] entry_word;
  logic [31:0] access_word;

  // ******************************************************
  // bus slave
  // ******************************************************
  // a write answers two edges after both halves arrive, a read two
  // edges after its address; masters should not rely on these
  // figures, since a wider bus front end may add wait states
  idp_axil u_axil (
    .aclk(aclk),
    .aresetn(aresetn),
    .awaddr(awaddr),
    .awvalid(awvalid),
    .awready(awready),
    .wdata(wdata),
    .wstrb(wstrb),
    .wvalid(wvalid),
    .wready(wready),
    .bresp(bresp),
    .bvalid(bvalid),
    .bready(bready),
    .araddr(araddr),
    .arvalid(arvalid),
    .arready(arready),
    .rdata(rdata),
    .rresp(rresp),
    .rvalid(rvalid),
    .rready(rready),
    .wr_en(wr_en),
    .wr_addr(wr_addr),
    .wr_data(wr_data),
    .wr_strb(wr_strb),
    .rd_addr(rd_addr),
    .rd_data(rd_data)
  );

  // ******************************************************
  // checker, fed straight from the request port
  // ******************************************************
  // purely combinational: the verdict is ready while the request is
  // offered and is registered only at the edge that takes it
  idp_check u_check (
    .usable(st_reg.usable),
    .lock(st_reg.lock),
    .etype(st_reg.etype),
    .sub_id(st_reg.sub_id),
    .wen(st_reg.wen),
    .ren(st_reg.ren),
    .pasid(req_pasid),
    .is_rd(req_rd),
    .is_wr(req_wr),
    .is_upd(req_upd),
    .err(chk_err),
    .need_bitmap(chk_need_bm)
  );

  // reserved bits read as zero
  assign entry_word = {st_reg.sub_id, 8'h00, st_reg.etype, st_reg.lock, st_reg.usable};
  assign access_word = {st_reg.acc_id, 9'h000, st_reg.priv, st_reg.wen, st_reg.ren};

  // ******************************************************
  // read mux
  // ******************************************************
  // the slave samples this one cycle after it took the address
  // unmapped addresses read zero; the slave flags them as errors
  always_comb begin
    unique case (rd_addr)
      ENTRY_OFS: rd_data = entry_word;
      ACCESS_OFS: rd_data = access_word;
      STATUS_OFS: rd_data = {30'h0000_0000, st_reg.status};
      MASK_OFS: rd_data = {30'h0000_0000, st_reg.mask};
      ERROR_OFS: rd_data = {28'h000_0000, st_reg.last_err};
      default: rd_data = 32'h0000_0000;
    endcase
  end

  // ******************************************************
  // next state
  // ******************************************************
  // writes and sequencer share one process so that the status update
  // sees the events and the clears of the same cycle together
  always_comb begin
    logic [31:0] merged;
    logic [EVT_W-1:0] evt_set;
    logic [EVT_W-1:0] evt_clr;
    merged = 32'h0000_0000;
    evt_set = '0;
    evt_clr = '0;
    st_next = st_reg;
    st_next.rsp_valid = 1'b0;

    // ---- register writes; guards use the flags as they stand before the write
    if (wr_en) begin
      unique case (wr_addr)
        ENTRY_OFS: begin
          merged = idp_merge(entry_word, wr_data, wr_strb);
          // the submitter identity is guarded by the usable flag alone
          if (!st_reg.usable) begin
            st_next.sub_id = merged[ID_LSB +: ID_W];
          end
          // type follows the same guard as the access word fields
          if (!st_reg.usable && !st_reg.lock) begin
            st_next.etype = merged[TYPE_LSB +: 2];
          end
          // flags stay open so software can always unlock the entry
          st_next.lock = merged[LOCK_BIT];
          st_next.usable = merged[USABLE_BIT];
        end
        ACCESS_OFS: begin
          merged = idp_merge(access_word, wr_data, wr_strb);
          // window attributes change by register only while both flags are clear
          if (!st_reg.usable && !st_reg.lock) begin
            st_next.acc_id = merged[ID_LSB +: ID_W];
            st_next.priv = merged[PRIV_BIT];
            st_next.wen = merged[WEN_BIT];
            st_next.ren = merged[REN_BIT];
          end
        end
        STATUS_OFS: begin
          // write one to clear; only byte lane 0 carries event bits
          if (wr_strb[0]) begin
            evt_clr = wr_data[EVT_W-1:0];
          end
        end
        MASK_OFS: begin
          // mask bits also live in byte lane 0
          if (wr_strb[0]) begin
            st_next.mask = wr_data[EVT_W-1:0];
          end
        end
        default: begin
          // the error code is read only
        end
      endcase
    end

    // ---- check sequencer
    unique case (st_reg.state)
      ST_IDLE: begin
        if (req_valid && st_reg.ready) begin
          // identity and privilege for the access are fixed at acceptance
          st_next.rsp_acc_id = st_reg.acc_id;
          st_next.rsp_priv = st_reg.priv ? req_priv : 1'b0;
          if (chk_need_bm) begin
            // multi-submitter entry: ask memory for the bitmap bit
            st_next.state = ST_BITMAP;
            st_next.bm_req = 1'b1;
            st_next.bm_pasid = req_pasid;
          end else begin
            // verdict is known now; a failure carries its own code
            st_next.rsp_valid = 1'b1;
            st_next.rsp_ok = (chk_err == ERR_NONE);
            st_next.rsp_err = chk_err;
            st_next.last_err = chk_err;
            evt_set[EVT_REJECT] = (chk_err != ERR_NONE);
            evt_set[EVT_ACCEPT] = (chk_err == ERR_NONE);
          end
        end
      end
      ST_BITMAP: begin
        // the request port stays closed until the lookup is answered
        if (bm_ack) begin
          // a clear bitmap bit refuses the submitter
          st_next.state = ST_IDLE;
          st_next.bm_req = 1'b0;
          st_next.rsp_valid = 1'b1;
          st_next.rsp_ok = bm_bit;
          st_next.rsp_err = bm_bit ? ERR_NONE : ERR_SUBMIT;
          st_next.last_err = bm_bit ? ERR_NONE : ERR_SUBMIT;
          evt_set[EVT_REJECT] = !bm_bit;
          evt_set[EVT_ACCEPT] = bm_bit;
        end
      end
    endcase

    // no new request while a lookup is outstanding
    // so the bitmap index cannot change in the middle of a lookup
    st_next.ready = (st_next.state == ST_IDLE);

    // ---- interrupts: a fresh event beats a clear in the same cycle
    // irq is registered from the next status, so it changes on the same edge as the status
    st_next.status = (st_reg.status & ~evt_clr) | evt_set;
    st_next.irq = |(st_next.status & st_next.mask);
  end

  // ******************************************************
  // state register
  // ******************************************************
  // synchronous reset; fields are named again so that their reset
  // values come from the package constants, not from the zero fill
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_reg <= '0;
      st_reg.sub_id <= ENTRY_RST[ID_LSB +: ID_W];
      st_reg.etype <= ENTRY_RST[TYPE_LSB +: 2];
      st_reg.lock <= ENTRY_RST[LOCK_BIT];
      st_reg.usable <= ENTRY_RST[USABLE_BIT];
      st_reg.acc_id <= ACCESS_RST[ID_LSB +: ID_W];
      st_reg.priv <= ACCESS_RST[PRIV_BIT];
      st_reg.wen <= ACCESS_RST[WEN_BIT];
      st_reg.ren <= ACCESS_RST[REN_BIT];
      st_reg.mask <= MASK_RST;
      st_reg.last_err <= ERR_NONE;
      st_reg.state <= ST_IDLE;
    end else begin
      st_reg <= st_next;
    end
  end

  // ******************************************************
  // outputs, each from the state register
  // ******************************************************
  // no logic between these registers and the pins
  assign req_ready = st_reg.ready;
  assign rsp_valid = st_reg.rsp_valid;
  assign rsp_ok = st_reg.rsp_ok;
  assign rsp_err = st_reg.rsp_err;
  assign rsp_acc_id = st_reg.rsp_acc_id;
  assign rsp_priv = st_reg.rsp_priv;
  assign bm_req = st_reg.bm_req;
  assign bm_pasid = st_reg.bm_pasid;
  assign irq = st_reg.irq;

endmodule

// File: inc/idp_pkg.sv
// package: register map, field layout, codes and helpers of the permission entry check
package idp_pkg;

  // ******************************************************
  // register map (byte addresses on the 8-bit bus address)
  // ******************************************************
  localparam int ADDR_W = 8;
  localparam logic [7:0] ENTRY_OFS = 8'h00;  // submitter identity, type, lock, usable
  localparam logic [7:0] ACCESS_OFS = 8'h04; // access identity, privilege, write, read
  localparam logic [7:0] STATUS_OFS = 8'h08; // sticky events, write one to clear
  localparam logic [7:0] MASK_OFS = 8'h0c;   // interrupt mask, same layout as status
  localparam logic [7:0] ERROR_OFS = 8'h10;  // code of the latest check

  // ******************************************************
  // field positions and reset values
  // ******************************************************
  localparam int ID_LSB = 12;       // both identity fields sit in bits 31:12
  localparam int ID_W = 20;
  localparam int TYPE_LSB = 2;      // entry type, bits 3:2
  localparam int LOCK_BIT = 1;      // update-lock flag
  localparam int USABLE_BIT = 0;    // usable flag
  localparam int PRIV_BIT = 2;      // access privilege control
  localparam int WEN_BIT = 1;       // write permission
  localparam int REN_BIT = 0;       // read permission
  localparam int EVT_W = 2;
  localparam int EVT_REJECT = 0;    // a descriptor was refused
  localparam int EVT_ACCEPT = 1;    // a descriptor was accepted
  localparam logic [31:0] ENTRY_RST = 32'h0000_0000;
  localparam logic [31:0] ACCESS_RST = 32'h0000_0000;
  localparam logic [1:0] MASK_RST = 2'h0;

  // ******************************************************
  // entry types and completion codes
  // ******************************************************
  localparam logic [1:0] TYPE_SINGLE = 2'h0; // single_access_single_submitter
  localparam logic [1:0] TYPE_MULTI = 2'h1;  // single_access_multi_submitter
  localparam logic [3:0] ERR_NONE = 4'h0;
  localparam logic [3:0] ERR_UNUSABLE = 4'h1;
  localparam logic [3:0] ERR_TYPE = 4'h2;
  localparam logic [3:0] ERR_UPDATE = 4'h3;
  localparam logic [3:0] ERR_WRITE = 4'h4;
  localparam logic [3:0] ERR_READ = 4'h5;
  localparam logic [3:0] ERR_SUBMIT = 4'h6;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // check sequencer states, one-hot
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_BITMAP = 2'b10
  } idp_state_e;

  // ******************************************************
  // helpers
  // ******************************************************
  // replace the bytes selected by the strobes
  function automatic logic [31:0] idp_merge(input logic [31:0] old_v,
                                            input logic [31:0] new_v,
                                            input logic [3:0] strb);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // true for an address that holds a register
  function automatic logic idp_mapped(input logic [7:0] a);
    return (a == ENTRY_OFS) || (a == ACCESS_OFS) || (a == STATUS_OFS) ||
           (a == MASK_OFS) || (a == ERROR_OFS);
  endfunction

endpackage

// File: sim/idp_bm_model.sv
// model: submitter bitmap memory answering the lookup handshake
module idp_bm_model
  import idp_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // lookup handshake
  input wire logic bm_req,
  input wire logic [ID_W-1:0] bm_pasid,
  output logic bm_ack,
  output logic bm_bit
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt; // idle cycles spent on the current lookup
  initial begin
    bm_ack = 1'b0;
    bm_bit = 1'b0;
  end
  // delay of 0..3 cycles from identity bits, so prompt and slow answers both occur
  always @(posedge aclk) begin
    bm_ack <= 1'b0;
    bm_bit <= ~bm_bit; // bit is meaningless outside the ack cycle, so never held
    if (!aresetn) begin
      cnt <= 0;
    end else if (bm_req && !bm_ack) begin
      if (cnt == int'(bm_pasid[2:1])) begin
        bm_ack <= 1'b1;
        bm_bit <= ^bm_pasid;
        cnt <= 0;
      end else begin
        cnt <= cnt + 1;
      end
    end
  end
endmodule

// File: sim/idp_chk.sv
// checker: timing and code checks on the verdict and bitmap ports
module idp_chk
  import idp_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // check request
  input wire logic req_valid,
  input wire logic req_ready,
  input wire logic [ID_W-1:0] req_pasid,
  input wire logic req_priv,
  // check answer
  input wire logic rsp_valid,
  input wire logic rsp_ok,
  input wire logic [3:0] rsp_err,
  input wire logic [ID_W-1:0] rsp_acc_id,
  input wire logic rsp_priv,
  // bitmap lookup
  input wire logic bm_req,
  input wire logic [ID_W-1:0] bm_pasid,
  input wire logic bm_ack,
  input wire logic bm_bit
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // a descriptor taken by the sequencer
  sequence s_take;
    req_valid && req_ready;
  endsequence
  // the outside finished a bitmap lookup
  sequence s_bm_done;
    bm_req && bm_ack;
  endsequence
  a_ok_code: assert property (rsp_valid |-> rsp_ok == (rsp_err == ERR_NONE))
    else $error("verdict flag and code disagree");
  a_take_answer: assert property (s_take |=> rsp_valid || bm_req)
    else $error("taken descriptor got no answer");
  a_user_priv: assert property ((s_take ##0 !req_priv) |=> !(rsp_valid && rsp_priv))
    else $error("privilege raised above the descriptor");
  a_bm_index: assert property ($rose(bm_req) |-> bm_pasid == $past(req_pasid))
    else $error("bitmap index is not the descriptor identity");
  a_bm_hold: assert property ((bm_req && !bm_ack) |=> bm_req && $stable(bm_pasid))
    else $error("bitmap request dropped early");
  a_bm_block: assert property (bm_req |-> !req_ready)
    else $error("ready while a lookup is pending");
  a_bm_refuse: assert property ((s_bm_done ##0 !bm_bit) |=> rsp_err == ERR_SUBMIT)
    else $error("clear bitmap bit not refused");
  a_bm_finish: assert property (s_bm_done |=> rsp_valid && !bm_req)
    else $error("no verdict after the lookup");
  a_acc_hold: assert property (!(req_valid && req_ready) |=> $stable(rsp_acc_id))
    else $error("access identity moved between verdicts");
endmodule

bind idp_top idp_chk u_chk (.aclk, .aresetn, .req_valid, .req_ready, .req_pasid, .req_priv,
  .rsp_valid, .rsp_ok, .rsp_err, .rsp_acc_id, .rsp_priv, .bm_req, .bm_pasid, .bm_ack, .bm_bit);

// File: sim/idp_top_tb.sv
// testbench: registers, descriptor checks and interrupt of the permission entry
module idp_top_tb
  import idp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, req_valid;
  logic req_priv, req_rd, req_wr, req_upd, awready, wready, bvalid, arready, rvalid;
  logic req_ready, rsp_valid, rsp_ok, rsp_priv, bm_req, bm_ack, bm_bit, irq;
  logic [ADDR_W-1:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb, rsp_err;
  logic [1:0] bresp, rresp;
  logic [ID_W-1:0] req_pasid, rsp_acc_id, bm_pasid;
  bit [31:0] ent, acc, r; // model of the entry and access words
  bit [1:0] sts, msk; // model of status and mask
  int ler, fails, comparisons, seed, i, j;

  idp_top DUT (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
    .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
    .req_valid, .req_ready, .req_pasid, .req_priv, .req_rd, .req_wr, .req_upd, .rsp_valid,
    .rsp_ok, .rsp_err, .rsp_acc_id, .rsp_priv, .bm_req, .bm_pasid, .bm_ack, .bm_bit, .irq);
  idp_bm_model u_bm (.aclk, .aresetn, .bm_req, .bm_pasid, .bm_ack, .bm_bit);

  // 25 mhz clock
  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end

  // ********
  // tasks
  // ********
  // count and report one comparison; case equality so unknowns never match
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      fails++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  // bus write, then the model applies the same protection
  task automatic wr(input logic [7:0] a, input bit [31:0] d);
    logic [1:0] er;
    bit [31:0] m;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    bready <= 1'b0;
    er = RESP_OKAY;
    m = (a == ACCESS_OFS) ? acc : ent;
    for (int k = 0; k < 4; k++) if (wstrb[k]) m[k*8 +: 8] = d[k*8 +: 8];
    case (a)
      ENTRY_OFS: begin
        if (!ent[0]) ent[31:12] = m[31:12];
        if (ent[1:0] == 2'h0) ent[3:2] = m[3:2];
        ent[1:0] = m[1:0];
      end
      ACCESS_OFS: if (ent[1:0] == 2'h0) acc = m;
      STATUS_OFS: sts &= ~d[1:0];
      MASK_OFS: msk = d[1:0];
      ERROR_OFS: ;
      default: er = RESP_SLVERR;
    endcase
    chk("bresp", er, bresp);
  endtask

  // bus read compared against the model word
  task automatic rd(input logic [7:0] a, input bit [31:0] e);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    rready <= 1'b0;
    chk("rdata", e, rdata);
    chk("rresp", (a > ERROR_OFS) ? RESP_SLVERR : RESP_OKAY, rresp);
  endtask

  // one descriptor check; the expected code follows the first failing check
  task automatic req(input bit [31:0] rr);
    int e;
    bit [19:0] p;
    p = rr[0] ? ent[31:12] : rr[31:12];
    if (!ent[0]) e = 1;
    else if (ent[3]) e = 2;
    else if (rr[4] && !ent[1]) e = 3;
    else if (rr[3] && !acc[1]) e = 4;
    else if (rr[2] && !acc[0]) e = 5;
    else if (!ent[2] && p != ent[31:12]) e = 6;
    else if (ent[2] && !(^p)) e = 6;
    else e = 0;
    @(posedge aclk);
    req_valid <= 1'b1;
    req_pasid <= p;
    req_priv <= rr[1];
    req_rd <= rr[2];
    req_wr <= rr[3];
    req_upd <= rr[4];
    do begin @(posedge aclk); end while (req_ready !== 1'b1);
    req_valid <= 1'b0;
    do begin @(posedge aclk); end while (rsp_valid !== 1'b1);
    chk("rsp_ok", e == 0, rsp_ok);
    chk("rsp_err", e, rsp_err);
    chk("rsp_acc_id", acc[31:12], rsp_acc_id);
    chk("rsp_priv", acc[2] & rr[1], rsp_priv);
    sts |= (e == 0) ? 2'h2 : 2'h1;
    ler = e;
  endtask

  // print the verdict and stop
  task automatic print_verdict;
    if (fails == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // ********
  // sequence
  // ********
  initial begin
    seed = 53;
    aresetn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready, req_valid} = '0;
    {awaddr, araddr, wdata, req_pasid, req_priv, req_rd, req_wr, req_upd} = '0;
    wstrb = 4'hf;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    for (i = 0; i < 6; i++) rd(8'(i * 4), 0);
    wr(8'h14, 32'h1);
    wr(MASK_OFS, 32'h1);
    req(0);
    repeat (3) @(posedge aclk);
    chk("irq", 1, irq);
    wr(STATUS_OFS, 32'h3);
    repeat (3) @(posedge aclk);
    chk("irq", 0, irq);
    // random entry contents, flags and descriptors against the model
    for (i = 0; i < 24; i++) begin
      r = $random(seed);
      wr(ENTRY_OFS, r & 32'hfffff00e);
      r = $random(seed);
      wstrb <= r[11:8];
      wr(ACCESS_OFS, r & 32'hfffff007);
      wstrb <= 4'hf;
      r = $random(seed);
      wr(ENTRY_OFS, (r & 32'hfffff00e) | 32'(i % 4 != 3));
      rd(ENTRY_OFS, ent);
      rd(ACCESS_OFS, acc);
      for (j = 0; j < 4; j++) req($random(seed));
    end
    rd(STATUS_OFS, sts);
    rd(ERROR_OFS, ler);
    repeat (3) @(posedge aclk);
    chk("irq", |(sts & msk), irq);
    print_verdict;
  end

  // watchdog well beyond the thousand or so cycles the run needs
  initial begin
    repeat (20000) @(posedge aclk);
    fails++;
    print_verdict;
  end
endmodule
